// file: lsd_map.svh
// Constants for the shift-latch LED sink driver
// What this block does
// - Serial-in parallel-out register of n stages, n is 8, 16, 24 or 32.
// - Every bit has a shift stage and a latch stage, each own clock.
// - Shift and latch clocks act on rising edges only, independently.
// - Shift edge loads serial input into stage one, moves others onward.
// - A latched high serial bit sinks its output low, low bit floats it.
// - Latch edge copies all shift stages to latch stages driving sinks.
// - Cascade output always shows the last shift stage for chaining.
// - Direct reset acts at once when its active-low input falls.
// - In reset stages are set, sinks float and cascade output is low.
// - Output enable high floats every sink, cascade keeps driving.
// - Output enable never affects shifting.
`ifndef LSD_MAP_SVH
`define LSD_MAP_SVH
`define LSD_BITS        8
`define LSD_BUF_DEPTH   2
`define LSD_STAGE_SET   1'B1
`define LSD_PIN_RESET   4'H1
`define LSD_PIN_WIDTH   4
`endif

// file: lsd_pkg.sv
// Types shared by the LED sink driver modules
package lsd_pkg;

  typedef struct packed {
    logic serial;
    logic shift_clk;
    logic latch_clk;
    logic oe_n;
  } lsd_pins_t;

  typedef struct packed {
    logic shift_rise;
    logic latch_rise;
  } lsd_edge_t;

endpackage

// file: lsd_sync.sv
// Two-flop synchroniser for asynchronous pins
`timescale 1ns/1ns
module lsd_sync #(
  parameter int               WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT  = '0
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_dout;

  always_comb
  begin
    next_meta = din;
    next_dout = meta;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta <= INIT;
      dout <= INIT;
    end
    else
    begin
      meta <= next_meta;
      dout <= next_dout;
    end
  end

endmodule // lsd_sync

// file: lsd_fifo2.sv
// Small valid/ready buffer for latch snapshots
`timescale 1ns/1ns
module lsd_fifo2 #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 2) ? $clog2(DEPTH) : 1;

  // Pointer wrap needs a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("lsd_fifo2: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wptr;
  logic [PW-1:0]    rptr;
  logic [PW:0]      count;
  logic [PW-1:0]    next_wptr;
  logic [PW-1:0]    next_rptr;
  logic [PW:0]      next_count;
  logic             push;
  logic             pop;

  always_comb
  begin
    in_ready   = (count != (PW+1)'(DEPTH));
    out_valid  = (count != '0);
    out_data   = mem[rptr];
    push       = in_valid && in_ready;
    pop        = out_valid && out_ready;
    next_wptr  = push ? wptr + PW'(1) : wptr;
    next_rptr  = pop ? rptr + PW'(1) : rptr;
    next_count = count + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end
    else
    begin
      wptr  <= next_wptr;
      rptr  <= next_rptr;
      count <= next_count;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wptr] <= in_data;
  end

endmodule // lsd_fifo2

// file: lsd_driver.sv
// Shift register, latch and open-drain sink outputs of the LED driver
`timescale 1ns/1ns
`include "lsd_map.svh"
module lsd_driver
  import lsd_pkg::*;
#(
  parameter int N     = `LSD_BITS,
  parameter int DEPTH = `LSD_BUF_DEPTH
) (
  input  wire logic         CLK,
  input  wire logic         RESET,
  input  wire logic         SERIAL_IN,
  input  wire logic         SHIFT_CLK,
  input  wire logic         LATCH_CLK,
  input  wire logic         DIRECT_RESET_N,
  input  wire logic         OUTPUT_ENABLE_N,
  output logic [N-1:0]      SINK_OUT,
  output logic [N-1:0]      SINK_OUT_OE_N,
  output logic              CASCADE_OUT
);

  if (N != 8 && N != 16 && N != 24 && N != 32)
  begin : g_bad_n
    $error("lsd_driver: N must be 8, 16, 24 or 32");
  end

  // Reset assembly: asserts at once, releases after two clocks
  logic rst_async;
  logic rst_meta;
  logic rst_hold;
  logic next_rst_meta;
  logic next_rst_hold;

  assign rst_async = RESET || !DIRECT_RESET_N;

  always_comb
  begin
    next_rst_meta = 1'B0;
    next_rst_hold = rst_meta;
  end

  always_ff @(posedge CLK or posedge rst_async)
  begin
    if (rst_async)
    begin
      rst_meta <= 1'B1;
      rst_hold <= 1'B1;
    end
    else
    begin
      rst_meta <= next_rst_meta;
      rst_hold <= next_rst_hold;
    end
  end

  // Pin synchronisers
  lsd_pins_t pins_raw;
  lsd_pins_t pins;

  always_comb
  begin
    pins_raw.serial    = SERIAL_IN;
    pins_raw.shift_clk = SHIFT_CLK;
    pins_raw.latch_clk = LATCH_CLK;
    pins_raw.oe_n      = OUTPUT_ENABLE_N;
  end

  lsd_sync #(
    .WIDTH (`LSD_PIN_WIDTH),
    .INIT  (`LSD_PIN_RESET)
  ) u_pin_sync (
    .clk  (CLK),
    .rst  (RESET),
    .din  (pins_raw),
    .dout (pins)
  );

  // Rising edge detection of both pin clocks
  logic      shift_prev;
  logic      latch_prev;
  logic      next_shift_prev;
  logic      next_latch_prev;
  lsd_edge_t edges;

  always_comb
  begin
    next_shift_prev  = pins.shift_clk;
    next_latch_prev  = pins.latch_clk;
    edges.shift_rise = pins.shift_clk && !shift_prev && !rst_hold;
    edges.latch_rise = pins.latch_clk && !latch_prev && !rst_hold;
  end

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      shift_prev <= 1'B1;
      latch_prev <= 1'B1;
    end
    else
    begin
      shift_prev <= next_shift_prev;
      latch_prev <= next_latch_prev;
    end
  end

  // Shift stages hold the sink pin level: low means sink on
  logic [N-1:0] stage;
  logic [N-1:0] next_stage;

  always_comb
  begin
    next_stage = stage;
    if (edges.shift_rise)
      next_stage = {stage[N-2:0], !pins.serial};
  end

  always_ff @(posedge CLK or posedge rst_hold)
  begin
    if (rst_hold)
      stage <= {N{`LSD_STAGE_SET}};
    else
      stage <= next_stage;
  end

  // Latch snapshot travels through the buffer
  logic         push_valid;
  logic         push_ready;
  logic         pend;
  logic         next_pend;
  logic         buf_valid;
  logic         buf_ready;
  logic [N-1:0] buf_data;

  always_comb
  begin
    push_valid = edges.latch_rise || pend;
    next_pend  = push_valid && !push_ready;
    buf_ready  = !rst_hold;
  end

  always_ff @(posedge CLK or posedge rst_hold)
  begin
    if (rst_hold)
      pend <= 1'B0;
    else
      pend <= next_pend;
  end

  lsd_fifo2 #(
    .WIDTH (N),
    .DEPTH (DEPTH)
  ) u_latch_buf (
    .clk       (CLK),
    .rst       (rst_hold),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (stage),
    .out_valid (buf_valid),
    .out_ready (buf_ready),
    .out_data  (buf_data)
  );

  // Latch stages, separate from the shift stages
  logic [N-1:0] latch;
  logic [N-1:0] next_latch;

  always_comb
  begin
    next_latch = latch;
    if (buf_valid && buf_ready)
      next_latch = buf_data;
  end

  always_ff @(posedge CLK or posedge rst_hold)
  begin
    if (rst_hold)
      latch <= {N{`LSD_STAGE_SET}};
    else
      latch <= next_latch;
  end

  // Output registers
  logic [N-1:0] next_sink_oe_n;
  logic         next_cascade;

  always_comb
  begin
    next_sink_oe_n = next_latch | {N{pins.oe_n}};
    next_cascade   = !next_stage[N-1];
  end

  always_ff @(posedge CLK or posedge rst_hold)
  begin
    if (rst_hold)
    begin
      SINK_OUT      <= '0;
      SINK_OUT_OE_N <= '1;
      CASCADE_OUT   <= 1'B0;
    end
    else
    begin
      SINK_OUT      <= '0;
      SINK_OUT_OE_N <= next_sink_oe_n;
      CASCADE_OUT   <= next_cascade;
    end
  end

  // Helper for the latch checks
  logic [N-1:0] snap_chk;

  always_ff @(posedge CLK or posedge rst_hold)
  begin
    if (rst_hold)
      snap_chk <= '1;
    else if (push_valid && push_ready)
      snap_chk <= stage;
  end

  sequence s_latch_taken;
    push_valid && push_ready;
  endsequence

  sequence s_latch_landed;
    ##2 (latch == snap_chk);
  endsequence

  property p_latch_copy;
    @(posedge CLK) disable iff (rst_hold)
      s_latch_taken ##1 !(push_valid && push_ready) |-> s_latch_landed;
  endproperty

  a_shift_moves_data: assert property (
    @(posedge CLK) disable iff (rst_hold)
      edges.shift_rise |=>
        stage == {$past(stage[N-2:0]), !$past(pins.serial)})
    else $error("shift stages did not move on a shift edge");

  a_no_edge_hold: assert property (
    @(posedge CLK) disable iff (rst_hold)
      !edges.shift_rise |=> stage == $past(stage))
    else $error("shift stages changed without a shift edge");

  a_latch_copies: assert property (p_latch_copy)
    else $error("latch stages did not take the shift snapshot");

  a_sink_follows_latch: assert property (
    @(posedge CLK) disable iff (rst_hold)
      !pins.oe_n && $stable(pins.oe_n) |=>
        SINK_OUT_OE_N == $past(next_latch))
    else $error("sink enables do not follow the latch stages");

  a_oe_floats_sinks: assert property (
    @(posedge CLK) disable iff (rst_hold)
      pins.oe_n |=> (&SINK_OUT_OE_N) && CASCADE_OUT == !stage[N-1])
    else $error("output enable high did not float the sinks");

  a_shift_with_oe: assert property (
    @(posedge CLK) disable iff (rst_hold)
      edges.shift_rise && pins.oe_n |=> stage[0] == !$past(pins.serial))
    else $error("shifting stopped while outputs were disabled");

  a_cascade_last: assert property (
    @(posedge CLK) disable iff (rst_hold)
      ##1 CASCADE_OUT == !stage[N-1])
    else $error("cascade output does not show the last stage");

  a_reset_state: assert property (
    @(posedge CLK)
      rst_hold |-> (&stage) && (&latch) && (&SINK_OUT_OE_N)
                   && !CASCADE_OUT)
    else $error("reset did not set the stages and float the sinks");

  a_reset_direct: assert property (
    @(posedge CLK)
      !DIRECT_RESET_N |-> rst_hold)
    else $error("direct reset did not act at once");

  a_reset_ignores: assert property (
    @(posedge CLK)
      rst_hold ##1 !rst_hold |-> (&stage) && (&latch))
    else $error("clock edges were taken during reset");

  a_sink_never_high: assert property (
    @(posedge CLK) disable iff (rst_hold)
      ##1 SINK_OUT == '0)
    else $error("sink pin driven other than low");

endmodule // lsd_driver

// file: lsd_host_model.sv
// Controller model driving the pin side of the LED sink driver
`timescale 1ns/1ns
module lsd_host_model #(
  parameter int N = 8
) (
  input  wire logic CLK,
  output logic      serial,
  output logic      shift_clk,
  output logic      latch_clk
);
  initial
  begin
    serial    = 1'B0;
    shift_clk = 1'B0;
    latch_clk = 1'B0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge CLK);
  endtask

  // Data stable well past the rising shift edge, then toggled
  task automatic shift_bit(input logic b);
    serial = b;
    wait_clk(4);
    shift_clk = 1'B1;
    wait_clk(4);
    shift_clk = 1'B0;
    serial    = ~b;
    wait_clk(4);
  endtask

  task automatic latch_pulse();
    latch_clk = 1'B1;
    wait_clk(4);
    latch_clk = 1'B0;
    wait_clk(8);
  endtask

  // All n bits first, latch afterwards
  task automatic send(input logic [N-1:0] w);
    for (int i = N - 1; i >= 0; i--)
      shift_bit(w[i]);
    wait_clk(4);
    latch_pulse();
  endtask
endmodule // lsd_host_model

// file: tb_top.sv
// Self-checking testbench of the LED sink driver
`timescale 1ns/1ns
module tb_top;
  localparam int N = 8;
  logic        CLK;
  logic        RESET;
  logic        SERIAL_IN;
  logic        SHIFT_CLK;
  logic        LATCH_CLK;
  logic        DIRECT_RESET_N;
  logic        OUTPUT_ENABLE_N;
  logic [N-1:0] SINK_OUT;
  logic [N-1:0] SINK_OUT_OE_N;
  logic        CASCADE_OUT;
  int          n_errors;
  int          total_checks;
  logic [31:0] seed;
  logic [N-1:0] w;
  logic [N-1:0] w2;

  lsd_driver #(.N(N), .DEPTH(2)) dut_u (
    .CLK(CLK), .RESET(RESET), .SERIAL_IN(SERIAL_IN),
    .SHIFT_CLK(SHIFT_CLK), .LATCH_CLK(LATCH_CLK),
    .DIRECT_RESET_N(DIRECT_RESET_N), .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N),
    .SINK_OUT(SINK_OUT), .SINK_OUT_OE_N(SINK_OUT_OE_N),
    .CASCADE_OUT(CASCADE_OUT)
  );

  lsd_host_model #(.N(N)) host_u (
    .CLK(CLK), .serial(SERIAL_IN), .shift_clk(SHIFT_CLK),
    .latch_clk(LATCH_CLK)
  );

  initial CLK = 1'B0;
  always #2 CLK = ~CLK;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  function automatic logic [N-1:0] exp_sink(input logic [N-1:0] d,
                                            input logic oe_n);
    return oe_n ? '1 : ~d;
  endfunction

  task automatic chk_vec(input logic [N-1:0] got, input logic [N-1:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    if (n_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    #40000;
    n_errors++;
    summarize();
  end

  initial
  begin
    n_errors        = 0;
    total_checks    = 0;
    seed            = 32'hB6D7;
    RESET           = 1'B1;
    DIRECT_RESET_N  = 1'B1;
    OUTPUT_ENABLE_N = 1'B0;
    repeat (6) @(negedge CLK);
    chk_vec(SINK_OUT_OE_N, '1);
    chk_bit(CASCADE_OUT, 1'B0);
    RESET = 1'B0;
    host_u.wait_clk(4);
    for (int i = 0; i < 8; i++)
    begin
      seed = xs(seed);
      w = (i == 0) ? '0 : (i == 1) ? '1 : (i == 2) ? 8'hA5 : seed[N-1:0];
      host_u.send(w);
      chk_vec(SINK_OUT_OE_N, exp_sink(w, 1'B0));
      chk_vec(SINK_OUT, '0);
      chk_bit(CASCADE_OUT, w[N-1]);
    end
    // Shift a new word without latching
    seed = xs(seed);
    w2 = seed[N-1:0];
    // Output enable drawn at random for each bit while shifting
    for (int j = N - 1; j >= 0; j--)
    begin
      seed = xs(seed);
      OUTPUT_ENABLE_N = seed[0];
      host_u.shift_bit(w2[j]);
      chk_bit(CASCADE_OUT, (j > 0) ? w[j-1] : w2[N-1]);
      chk_vec(SINK_OUT_OE_N, exp_sink(w, seed[0]));
    end
    OUTPUT_ENABLE_N = 1'B0;
    host_u.wait_clk(4);
    chk_vec(SINK_OUT_OE_N, exp_sink(w, 1'B0));
    host_u.latch_pulse();
    chk_vec(SINK_OUT_OE_N, exp_sink(w2, 1'B0));
    // Outputs disabled while shifting and latching go on
    OUTPUT_ENABLE_N = 1'B1;
    host_u.wait_clk(6);
    chk_vec(SINK_OUT_OE_N, exp_sink(w2, 1'B1));
    chk_bit(CASCADE_OUT, w2[N-1]);
    seed = xs(seed);
    w = seed[N-1:0];
    host_u.send(w);
    chk_vec(SINK_OUT_OE_N, '1);
    chk_bit(CASCADE_OUT, w[N-1]);
    OUTPUT_ENABLE_N = 1'B0;
    host_u.wait_clk(6);
    chk_vec(SINK_OUT_OE_N, exp_sink(w, 1'B0));
    // Direct reset in mid-run, with clock edges during it
    DIRECT_RESET_N = 1'B0;
    #1;
    chk_vec(SINK_OUT_OE_N, '1);
    chk_bit(CASCADE_OUT, 1'B0);
    host_u.wait_clk(1);
    host_u.shift_bit(1'B1);
    host_u.latch_pulse();
    chk_vec(SINK_OUT_OE_N, '1);
    DIRECT_RESET_N = 1'B1;
    host_u.wait_clk(6);
    chk_vec(SINK_OUT_OE_N, '1);
    chk_bit(CASCADE_OUT, 1'B0);
    w = 8'h3C;
    host_u.send(w);
    chk_vec(SINK_OUT_OE_N, exp_sink(w, 1'B0));
    summarize();
  end
endmodule // tb_top
